// ==== sim/sar_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker
// ****
module sar_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic convert_strobe_n,
  input wire logic sck,
  input wire logic compAbove,
  input wire logic sdo_q,
  input wire logic sdoEn_q,
  input wire logic [12:0] capApproxArray_q,
  input wire logic sampling_q,
  input wire logic converting_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_START: assert property ($fell(convert_strobe_n) && sampling_q |-> ##[1:4] converting_q)
    else $error("no start");
  AST_TRIAL: assert property ($rose(converting_q) |-> capApproxArray_q == 13'h1000)
    else $error("bad trial");
  AST_PHASE: assert property (sampling_q != sdoEn_q)
    else $error("bad phase");
  AST_EXCL: assert property (sampling_q |-> !converting_q)
    else $error("both phases");
  AST_HIGH: assert property (convert_strobe_n [*5] |-> sampling_q)
    else $error("no sampling");
  AST_LOW: assert property (!convert_strobe_n [*5] |-> sdoEn_q)
    else $error("no data");
  AST_SDO: assert property ((sdoEn_q && $stable(sck) && $stable(convert_strobe_n)) [*5]
    |=> $stable(sdo_q))
    else $error("sdo moved");
  AST_HOLD: assert property (sampling_q && $past(sampling_q) |-> $stable(capApproxArray_q))
    else $error("array moved");
endmodule
bind sar_conversion_serial_readout sar_chk sar_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .convert_strobe_n(convert_strobe_n), .sck(sck), .compAbove(compAbove), .sdo_q(sdo_q),
  .sdoEn_q(sdoEn_q), .capApproxArray_q(capApproxArray_q), .sampling_q(sampling_q),
  .converting_q(converting_q));
`default_nettype wire

// ==== sim/sar_conversion_serial_readout_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module sar_conversion_serial_readout_test;
  logic clkSys;
  logic rstN;
  wire strobeN, sck, compAbove, sdo, sdoEn, sampling, converting;
  wire [12:0] trial;
  integer errors;
  integer checks;
  logic [12:0] got;
  logic [12:0] prevWord;
  logic [12:0] codes [0:5];
  sar_conversion_serial_readout sar_conversion_serial_readout_inst (.clk_sys(clkSys),
    .rst_n(rstN), .convert_strobe_n(strobeN), .sck(sck), .compAbove(compAbove),
    .sdo_q(sdo), .sdoEn_q(sdoEn), .capApproxArray_q(trial), .sampling_q(sampling),
    .converting_q(converting));
  sar_host_model sar_host_model_inst (.sdo_q(sdo), .capApproxArray_q(trial),
    .convert_strobe_n(strobeN), .sck(sck), .compAbove(compAbove));
  task check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task test_first;
    sar_host_model_inst.frame(13'h0000, got);
    check("first word", got, 13'h0000);
    $display("test_first done");
  endtask
  task test_codes;
    for (int i = 0; i < 6; i++) begin
      sar_host_model_inst.frame(codes[i], got);
      check("word", got, prevWord);
      prevWord = codes[i];
    end
    sar_host_model_inst.frame(13'h0000, got);
    check("last word", got, prevWord);
    $display("test_codes done");
  endtask
  task test_cut;
    prevWord = 13'h0A5C;
    sar_host_model_inst.frame(prevWord, got);
    check("word before cut", got, 13'h0000);
    sar_host_model_inst.cut_frame(13'h0123, 5, got);
    check("cut bits", {8'h00, got[4:0]}, {8'h00, prevWord[12:8]});
    sar_host_model_inst.frame(13'h0777, got);
    check("word after cut", got, 13'h0000);
    sar_host_model_inst.frame(13'h0000, got);
    check("word after full", got, 13'h0777);
    $display("test_cut done");
  endtask
  task test_reset;
    sar_host_model_inst.frame(13'h0ABC, got);
    check("word before reset", got, 13'h0000);
    rstN = 1'b0;
    repeat (6) @(posedge clkSys);
    #2 rstN = 1'b1;
    repeat (2) @(posedge clkSys);
    #2;
    sar_host_model_inst.frame(13'h1234, got);
    check("word after reset", got, 13'h0000);
    sar_host_model_inst.frame(13'h0000, got);
    check("word after restart", got, 13'h1234);
    $display("test_reset done");
  endtask
  initial begin
    clkSys = 1'b0;
    forever #5 clkSys = ~clkSys;
  end
  initial begin
    #60000;
    errors = errors + 1;
    complete_run();
  end
  initial begin
    errors = 0;
    checks = 0;
    rstN = 1'b0;
    prevWord = 13'h0000;
    codes = '{13'h1000, 13'h0FFF, 13'h1800, 13'h07FF, 13'h1FFF, 13'h0001};
    repeat (6) @(posedge clkSys);
    #2 rstN = 1'b1;
    repeat (2) @(posedge clkSys);
    #2;
    test_first();
    test_codes();
    test_cut();
    test_reset();
    complete_run();
  end
endmodule
`default_nettype wire

// ==== sim/sar_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Host and analog side
// ****
module sar_host_model (
  input wire logic sdo_q,
  input wire logic [12:0] capApproxArray_q,
  output logic convert_strobe_n,
  output logic sck,
  output logic compAbove
);
  logic [12:0] target;
  // The held input is target seen in offset binary, so a correct search lands on it exactly.
  assign compAbove = (target ^ 13'h1000) >= capApproxArray_q;
  initial begin
    target = 13'h0000;
    convert_strobe_n = 1'b1;
    sck = 1'b1;
  end
  // Only single-ended signalling is modelled; the select strap stays on the board.
  task automatic frame(input logic [12:0] w, output logic [12:0] got);
    cut_frame(w, 13, got);
  endtask
  // Fewer than 13 falls lets a scenario cut a conversion short on purpose.
  task automatic cut_frame(input logic [12:0] w, input int falls, output logic [12:0] got);
    target = w;
    convert_strobe_n = 1'b0;
    #80;
    repeat (falls) begin
      got = {got[11:0], sdo_q};
      sck = 1'b0;
      #40;
      sck = 1'b1;
      #40;
    end
    convert_strobe_n = 1'b1;
    #80;
  endtask
endmodule
`default_nettype wire

// ==== verilog/sar_conversion_serial_readout.v ====
// Behaviour
// RL1: A falling edge on the convert strobe ends sampling and starts a conversion.
// RL2: Each shift clock falling edge makes one approximation decision on the 13-bit array.
// RL3: Results are 13-bit two's complement words; the top bit is the sign.
// RL4: Bits shifted out during a cycle belong to the previous conversion.
// RL5: One result per strobe cycle, up to 5Msps, latency exactly one cycle.
// RL6: Fully differential codes run from 1 0000 0000 0000 to 0 1111 1111 1111.
// RL7: Fully differential drive uses all 2^13 codes over twice the reference.
// RL8: Pseudo-differential drive covers 2^12 codes and still codes over/under range.
// RL9: Pseudo-differential bipolar codes run from 11 000 0000 0000 to 00 111 1111 1111.
// RL10: Host clamps out-of-span pseudo-differential codes itself if it must.
// RL11: One code step equals 1mV at a 4.096V reference, scaling with it.
// RL12: All input kinds are coded identically; there is no mode setting.
// RL13: Strobe high keeps sampling; strobe low starts conversion and releases data.
// RL14: Result goes out MSB first, one new bit per shift clock falling edge.
// RL15: Board straps the interface select pin for the output signalling.
// RL16: Host supplies at least 13 falling edges per cycle and assembles the word.
// RL17: Host discards the first word after conversions start.
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.vh"

// ****************************************************************
// Result FIFO
// ****************************************************************
module sar_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doWrite;
  wire doRead;

  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q];
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;

  always @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead && !doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ****************************************************************
// Converter control and serial readout
// ****************************************************************
module sar_conversion_serial_readout (
  input wire clk_sys,
  input wire rst_n,
  input wire convert_strobe_n,
  input wire sck,
  input wire compAbove,
  output reg sdo_q,
  output reg sdoEn_q,
  output reg [`SAR_MSB:0] capApproxArray_q,
  output reg sampling_q,
  output reg converting_q
);
  reg cnvMeta_q;
  reg cnvSync_q;
  reg cnvPrev_q;
  reg sckMeta_q;
  reg sckSync_q;
  reg sckPrev_q;
  reg compMeta_q;
  reg compSync_q;
  reg [`SAR_STEP_W-1:0] step_q;
  reg [`SAR_MSB:0] shift_q;
  reg [`SAR_MSB:0] result_q;
  reg pending_q;
  wire cnvFall;
  wire cnvRise;
  wire sckFall;
  wire fifoInReady;
  wire [`SAR_MSB:0] fifoOutData;
  wire fifoOutValid;
  wire fifoPop;
  wire [`SAR_MSB:0] decided;

  // Resolves the current bit from the comparator and proposes the next lower one.
  function [`SAR_MSB:0] sarStep;
    input [`SAR_MSB:0] trial;
    input [`SAR_STEP_W-1:0] idx;
    input above;
    reg [`SAR_MSB:0] t;
    begin
      t = trial;
      t[idx] = above;
      if (idx != `SAR_LAST_STEP) begin
        t[idx - 1'b1] = 1'b1;
      end
      sarStep = t;
    end
  endfunction

  assign cnvFall = cnvPrev_q & ~cnvSync_q;
  assign cnvRise = ~cnvPrev_q & cnvSync_q;
  assign sckFall = sckPrev_q & ~sckSync_q;
  assign decided = sarStep(capApproxArray_q, step_q, compSync_q);
  assign fifoPop = cnvFall & fifoOutValid;

  // Both pins and the comparator come from outside the clock domain.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnvMeta_q <= 1'b1;
      cnvSync_q <= 1'b1;
      cnvPrev_q <= 1'b1;
      sckMeta_q <= 1'b0;
      sckSync_q <= 1'b0;
      sckPrev_q <= 1'b0;
      compMeta_q <= 1'b0;
      compSync_q <= 1'b0;
    end else begin
      cnvMeta_q <= convert_strobe_n;
      cnvSync_q <= cnvMeta_q;
      cnvPrev_q <= cnvSync_q;
      sckMeta_q <= sck;
      sckSync_q <= sckMeta_q;
      sckPrev_q <= sckSync_q;
      compMeta_q <= compAbove;
      compSync_q <= compMeta_q;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sampling_q <= 1'b1;
      converting_q <= 1'b0;
      sdoEn_q <= 1'b0;
      sdo_q <= 1'b0;
      step_q <= `SAR_FIRST_STEP;
      capApproxArray_q <= `SAR_WORD_ZERO;
      shift_q <= `SAR_WORD_ZERO;
      result_q <= `SAR_WORD_ZERO;
      pending_q <= 1'b0;
    end else begin
      if (pending_q && fifoInReady) begin
        pending_q <= 1'b0;
      end
      if (cnvFall) begin
        sampling_q <= 1'b0; // [RL1] [RL13]
        converting_q <= 1'b1; // [RL1]
        step_q <= `SAR_FIRST_STEP;
        capApproxArray_q <= `SAR_TRIAL_START;
        sdoEn_q <= 1'b1; // [RL13]
        // The word loaded here was finished in the previous cycle. [RL4] [RL5]
        if (fifoOutValid) begin
          shift_q <= {fifoOutData[`SAR_MSB-1:0], 1'b0};
          sdo_q <= fifoOutData[`SAR_MSB]; // [RL14]
        end else begin
          shift_q <= `SAR_WORD_ZERO;
          sdo_q <= 1'b0;
        end
      end else if (cnvRise) begin
        // A conversion short of edges is dropped rather than emitted half built.
        sampling_q <= 1'b1; // [RL13]
        converting_q <= 1'b0;
        sdoEn_q <= 1'b0;
      end else if (sckFall) begin
        if (sdoEn_q) begin
          sdo_q <= shift_q[`SAR_MSB]; // [RL14]
          shift_q <= {shift_q[`SAR_MSB-1:0], 1'b0};
        end
        if (converting_q && !pending_q) begin
          capApproxArray_q <= decided; // [RL2]
          if (step_q == `SAR_LAST_STEP) begin
            converting_q <= 1'b0;
            pending_q <= 1'b1;
            // Offset-binary trial becomes two's complement by flipping the sign bit;
            // every input kind gets this same coding. [RL3] [RL6] [RL7] [RL8] [RL9] [RL11] [RL12]
            result_q <= decided ^ `SAR_SIGN_FLIP;
          end else begin
            step_q <= step_q - 1'b1; // [RL2]
          end
        end
      end
    end
  end

  sar_fifo #(
    .WIDTH(`SAR_RES_BITS),
    .DEPTH(`SAR_FIFO_DEPTH),
    .AW(`SAR_FIFO_AW)
  ) sar_fifo_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inData(result_q),
    .inValid(pending_q),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );
endmodule

`default_nettype wire

// ==== verilog/sar_regs.vh ====
`ifndef SAR_CONV_REGS_VH
`define SAR_CONV_REGS_VH

// ****************************************************************
// Word format and approximation sequence
// ****************************************************************
`define SAR_RES_BITS 13
`define SAR_MSB 12
`define SAR_STEP_W 4
`define SAR_FIRST_STEP 4'hC
`define SAR_LAST_STEP 4'h0
`define SAR_TRIAL_START 13'h1000
`define SAR_SIGN_FLIP 13'h1000
`define SAR_WORD_ZERO 13'h0000

// ****************************************************************
// Result buffer
// ****************************************************************
`define SAR_FIFO_DEPTH 32
`define SAR_FIFO_AW 5

`endif
